/* File: design/ism_pkg.sv */
// Function
// - Plain sleep stops primary, clears primary flag
// - Gate and source bits reset to zero
// - Sleep wake withholds clocks unless fast start
// - Primary flag set when primary drives system
// - Wake never alters gate or source bits
// - Idle stops CPU, peripherals keep selected source
// - Idle exits only on interrupt, watchdog, reset
// - Idle wake holds CPU about ten microseconds
// - Run on idle source until primary ready
// - Watchdog in low power wakes, never resets
// - Primary idle keeps primary and its flag
// - Primary idle wake stays on primary, flag set
// - Secondary idle switches, sets secondary flag
// - Secondary disabled: sleep becomes forced no-op
// - Secondary not oscillating: delay peripheral clocks
// - Secondary idle wake: swap flags after switch
// - Upper select bit picks internal multiplexer idle
// - Internal stable flag after about one millisecond
// - Already stable fast source keeps flag set
// - Zero frequency field: fast source off, flag clear
// - Internal idle wake: clear internal, set primary
// - Slow internal runs with watchdog or monitor
// - Switch pauses for eight new-source edges
// - At most one status flag outside primary run
package ism_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HOLDOFF = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Control register field positions
  localparam int CTRL_SRC_LO = 0;
  localparam int CTRL_FREQ_LO = 4;
  localparam int CTRL_GATE = 7;
  localparam int CTRL_SEC_EN = 8;
  localparam int CTRL_WDT_EN = 9;
  localparam int CTRL_MON_EN = 10;
  localparam int CTRL_FAST_START = 11;

  // Status register field positions
  localparam int STAT_PRIMARY = 0;
  localparam int STAT_INTERNAL = 1;
  localparam int STAT_SECONDARY = 2;
  localparam int STAT_FSM_LO = 4;

  // Clock-source select codes
  localparam logic [1:0] SRC_PRIMARY = 2'h0;
  localparam logic [1:0] SRC_SECONDARY = 2'h1;

  // System clock source indication on sys_src
  localparam logic [1:0] SYS_NONE = 2'h0;
  localparam logic [1:0] SYS_PRIMARY = 2'h1;
  localparam logic [1:0] SYS_SECONDARY = 2'h2;
  localparam logic [1:0] SYS_INTERNAL = 2'h3;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int HOLDOFF_NS = 10000;
  localparam int SETTLE_NS = 1000000;
  localparam int HOLDOFF_CYC = HOLDOFF_NS / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SWITCH_EDGES = 8;

  // Reset values
  localparam logic [11:0] CTRL_RESET = 12'h000;
  localparam logic [15:0] HOLDOFF_RESET = 16'(HOLDOFF_CYC);

  // Low-power mode captured at the sleep instruction
  typedef enum logic [1:0] {
    LP_SLEEP = 2'h0,
    LP_PRIMARY = 2'h1,
    LP_SECONDARY = 2'h2,
    LP_INTERNAL = 2'h3
  } ism_lp_t;

  // Sequencer states, Gray along the usual path except the ST_SWITCH_BACK to ST_RUN step
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_SWITCH_IN = 3'h1,
    ST_LOW = 3'h3,
    ST_WAKE_HOLD = 3'h2,
    ST_ALT_RUN = 3'h6,
    ST_SWITCH_BACK = 3'h7,
    ST_WAIT_SEC = 3'h5,
    ST_SLEEP_WAKE = 3'h4
  } ism_state_t;

endpackage

/* File: design/ism_edge_counter.sv */
// Counts rising edges of a foreign clock after a restart pulse
module ism_edge_counter #(
  parameter int EDGES = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic src_clk,
  // Result
  output logic done
);

  // Elaboration-time guard on the edge count
  if (EDGES < 1 || EDGES > 255) begin : g_bad
    $error("EDGES out of range");
  end

  // Whole state of the counter
  typedef struct packed {
    logic [1:0] sync;
    logic prev;
    logic [7:0] cnt;
  } ism_ec_t;

  ism_ec_t s_q, s_d;

  // Next state: sync stage one feeds only stage two
  always_comb begin
    s_d = s_q;
    s_d.sync = {s_q.sync[0], src_clk};
    s_d.prev = s_q.sync[1];
    if (start) begin
      s_d.cnt = 8'h00; // Restart on each switch
    end else if (s_q.sync[1] && !s_q.prev && s_q.cnt < 8'(EDGES)) begin
      s_d.cnt = s_q.cnt + 8'h01; // Rising edge of the new source
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Done once the full count is seen; not gated by start, which the sequencer derives from done
  assign done = (s_q.cnt == 8'(EDGES));

endmodule

/* File: design/ism_clock_manager.sv */
// Power-managed mode sequencer with APB register access
//
// The implementer's own choices: the address map and the APB slave port.
module ism_clock_manager #(
  parameter int SETTLE_CYCLES = ism_pkg::SETTLE_CYC,
  parameter int SWITCH_EDGES = ism_pkg::SWITCH_EDGES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU core
  input wire logic sleep_instr,
  output logic forced_nop,
  output logic cpu_clk_en,
  // Wake sources
  input wire logic irq_wake,
  input wire logic wdt_timeout,
  output logic wdt_reset_req,
  // Oscillator pins
  input wire logic primary_osc_clk,
  input wire logic secondary_osc_clk,
  input wire logic internal_mux_clk,
  input wire logic primary_ready,
  input wire logic secondary_running,
  // Clock tree control
  output logic periph_clk_en,
  output logic [1:0] sys_src,
  output logic primary_osc_en,
  output logic fast_internal_en,
  output logic slow_internal_en
);

  // Settling counter must fit its register
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 262143) begin : g_bad
    $error("SETTLE_CYCLES out of range");
  end

  // Whole state of the block
  typedef struct packed {
    ism_pkg::ism_state_t st;
    ism_pkg::ism_lp_t lp;
    logic [11:0] ctrl;
    logic [15:0] holdoff;
    logic [15:0] hold_cnt;
    logic [17:0] settle_cnt;
    logic fast_stable;
    logic flag_primary;
    logic flag_internal;
    logic flag_secondary;
    logic nop;
    logic [1:0] irq_sync;
    logic [1:0] wdt_sync;
    logic [1:0] prdy_sync;
    logic [1:0] srun_sync;
  } ism_state_all_t;

  ism_state_all_t s_q, s_d;

  // Field views of the control register
  logic gate;
  logic [1:0] src;
  logic [2:0] freq;
  logic fast_start;
  logic wake;
  logic sw_start;
  logic sw_done;
  logic sw_clk;
  logic apb_wr;
  logic mapped;

  assign gate = s_q.ctrl[ism_pkg::CTRL_GATE];
  assign src = s_q.ctrl[ism_pkg::CTRL_SRC_LO +: 2];
  assign freq = s_q.ctrl[ism_pkg::CTRL_FREQ_LO +: 3];
  assign fast_start = s_q.ctrl[ism_pkg::CTRL_FAST_START] | s_q.ctrl[ism_pkg::CTRL_MON_EN];

  // Only interrupt or watchdog restarts the CPU; reset is rst_n
  assign wake = s_q.irq_sync[1] | s_q.wdt_sync[1];

  // Decode helpers
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == ism_pkg::OFS_CTRL) || (a == ism_pkg::OFS_HOLDOFF) || (a == ism_pkg::OFS_STATUS);
  endfunction

  // Zero-wait APB: each access completes in its first access cycle
  assign mapped = is_mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign apb_wr = psel & penable & pwrite & mapped;

  // Read mux; unmapped and reserved bits read zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      unique case (paddr)
        ism_pkg::OFS_CTRL: prdata = {20'h00000, s_q.ctrl};
        ism_pkg::OFS_HOLDOFF: prdata = {16'h0000, s_q.holdoff};
        ism_pkg::OFS_STATUS: prdata = {25'h0000000, 3'(s_q.st), 1'b0, s_q.flag_secondary,
                                       s_q.flag_internal, s_q.flag_primary};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // Switch counter restarts on entering either switching state
  assign sw_start = ((s_d.st == ism_pkg::ST_SWITCH_IN) || (s_d.st == ism_pkg::ST_SWITCH_BACK)) &&
                    (s_d.st != s_q.st);

  // New source being counted
  always_comb begin
    if (s_q.st == ism_pkg::ST_SWITCH_BACK) begin
      sw_clk = primary_osc_clk;
    end else if (s_q.lp == ism_pkg::LP_SECONDARY) begin
      sw_clk = secondary_osc_clk;
    end else begin
      sw_clk = internal_mux_clk;
    end
  end

  // Eight-edge synchroniser for every clock switch
  ism_edge_counter #(
    .EDGES(SWITCH_EDGES)
  ) u_switch (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(sw_start),
    .src_clk(sw_clk),
    .done(sw_done)
  );

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.nop = 1'b0;
    // Pin synchronisers; stage one is read only by stage two
    s_d.irq_sync = {s_q.irq_sync[0], irq_wake};
    s_d.wdt_sync = {s_q.wdt_sync[0], wdt_timeout};
    s_d.prdy_sync = {s_q.prdy_sync[0], primary_ready};
    s_d.srun_sync = {s_q.srun_sync[0], secondary_running};

    // Software writes only; the sequencer never touches ctrl
    if (apb_wr && paddr == ism_pkg::OFS_CTRL) begin
      s_d.ctrl = pwdata[11:0];
    end
    if (apb_wr && paddr == ism_pkg::OFS_HOLDOFF) begin
      s_d.holdoff = pwdata[15:0];
    end

    // Fast internal source settling
    if (freq == 3'h0) begin
      s_d.fast_stable = 1'b0;
      s_d.settle_cnt = 18'h00000;
    end else if (!s_q.fast_stable) begin
      if (s_q.settle_cnt >= 18'(SETTLE_CYCLES - 1)) begin
        s_d.fast_stable = 1'b1;
      end else begin
        s_d.settle_cnt = s_q.settle_cnt + 18'h00001;
      end
    end

    unique case (s_q.st)
      // Full-power run on the primary source
      ism_pkg::ST_RUN: begin
        if (sleep_instr) begin
          if (!gate && src == ism_pkg::SRC_PRIMARY) begin
            s_d.lp = ism_pkg::LP_SLEEP;
            s_d.st = ism_pkg::ST_LOW;
            s_d.flag_primary = 1'b0;
            s_d.flag_internal = 1'b0;
            s_d.flag_secondary = 1'b0;
          end else if (gate && src == ism_pkg::SRC_PRIMARY) begin
            s_d.lp = ism_pkg::LP_PRIMARY;
            s_d.st = ism_pkg::ST_LOW;
          end else if (gate && src == ism_pkg::SRC_SECONDARY) begin
            if (!s_q.ctrl[ism_pkg::CTRL_SEC_EN]) begin
              s_d.nop = 1'b1;
            end else begin
              s_d.lp = ism_pkg::LP_SECONDARY;
              s_d.st = s_q.srun_sync[1] ? ism_pkg::ST_SWITCH_IN : ism_pkg::ST_WAIT_SEC;
            end
          end else if (gate) begin
            s_d.lp = ism_pkg::LP_INTERNAL;
            s_d.st = ism_pkg::ST_SWITCH_IN;
          end else begin
            s_d.nop = 1'b1; // Run modes are not served here
          end
        end
      end
      // Secondary enabled but not oscillating yet
      ism_pkg::ST_WAIT_SEC: begin
        if (s_q.srun_sync[1]) begin
          s_d.st = ism_pkg::ST_SWITCH_IN;
        end
      end
      // Clocks paused while the new source is counted in
      ism_pkg::ST_SWITCH_IN: begin
        if (sw_done) begin
          s_d.st = ism_pkg::ST_LOW;
          s_d.flag_primary = 1'b0;
          s_d.flag_secondary = (s_q.lp == ism_pkg::LP_SECONDARY);
        end
      end
      // Sleep or idle; wake by interrupt or watchdog
      ism_pkg::ST_LOW: begin
        if (wake) begin
          if (s_q.lp == ism_pkg::LP_SLEEP) begin
            s_d.st = ism_pkg::ST_SLEEP_WAKE;
          end else begin
            s_d.st = ism_pkg::ST_WAKE_HOLD;
            s_d.hold_cnt = 16'h0000;
          end
        end
      end
      // CPU held off after an idle wake
      ism_pkg::ST_WAKE_HOLD: begin
        if (s_q.hold_cnt + 16'h0001 >= s_q.holdoff) begin
          s_d.st = (s_q.lp == ism_pkg::LP_PRIMARY) ? ism_pkg::ST_RUN : ism_pkg::ST_ALT_RUN;
        end else begin
          s_d.hold_cnt = s_q.hold_cnt + 16'h0001;
        end
      end
      // CPU runs on the idle source until primary is ready
      ism_pkg::ST_ALT_RUN: begin
        if (s_q.prdy_sync[1]) begin
          s_d.st = ism_pkg::ST_SWITCH_BACK;
        end
      end
      // Sleep wake: wait for primary, clocks withheld or internal
      ism_pkg::ST_SLEEP_WAKE: begin
        if (s_q.prdy_sync[1]) begin
          s_d.st = ism_pkg::ST_SWITCH_BACK;
        end
      end
      // Switch back to primary after eight of its edges
      ism_pkg::ST_SWITCH_BACK: begin
        if (sw_done) begin
          s_d.st = ism_pkg::ST_RUN;
          s_d.flag_primary = 1'b1;
          s_d.flag_secondary = 1'b0;
          s_d.flag_internal = 1'b0;
        end
      end
    endcase

    // Internal flag only while the settled fast source drives the system
    if (s_d.lp == ism_pkg::LP_INTERNAL && !s_d.flag_primary && s_d.st != ism_pkg::ST_SWITCH_IN &&
        s_d.st != ism_pkg::ST_RUN) begin
      s_d.flag_internal = s_d.fast_stable;
    end
  end

  // State register; control bits reset to zero for Sleep selection
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= ism_pkg::ST_RUN;
      s_q.lp <= ism_pkg::LP_SLEEP;
      s_q.ctrl <= ism_pkg::CTRL_RESET;
      s_q.holdoff <= ism_pkg::HOLDOFF_RESET;
      s_q.flag_primary <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Forced no-op pulse back to the core
  assign forced_nop = s_q.nop;

  // Watchdog resets only in full-power run; in sleep or idle it wakes
  assign wdt_reset_req = s_q.wdt_sync[1] && (s_q.st == ism_pkg::ST_RUN);

  // Clock tree control from the sequencer state
  always_comb begin
    cpu_clk_en = 1'b0;
    periph_clk_en = 1'b0;
    sys_src = ism_pkg::SYS_NONE;
    primary_osc_en = 1'b1;
    unique case (s_q.st)
      ism_pkg::ST_RUN: begin
        cpu_clk_en = 1'b1;
        periph_clk_en = 1'b1;
        sys_src = ism_pkg::SYS_PRIMARY;
      end
      ism_pkg::ST_WAIT_SEC, ism_pkg::ST_SWITCH_IN: begin
        primary_osc_en = 1'b0; // Clocks paused during the switch
      end
      ism_pkg::ST_LOW, ism_pkg::ST_WAKE_HOLD, ism_pkg::ST_ALT_RUN: begin
        // Idle keeps peripherals on the selected source
        periph_clk_en = (s_q.lp != ism_pkg::LP_SLEEP);
        cpu_clk_en = (s_q.st == ism_pkg::ST_ALT_RUN);
        primary_osc_en = (s_q.lp == ism_pkg::LP_PRIMARY) || (s_q.st == ism_pkg::ST_ALT_RUN);
        unique case (s_q.lp)
          ism_pkg::LP_PRIMARY: sys_src = ism_pkg::SYS_PRIMARY;
          ism_pkg::LP_SECONDARY: sys_src = ism_pkg::SYS_SECONDARY;
          ism_pkg::LP_INTERNAL: sys_src = ism_pkg::SYS_INTERNAL;
          ism_pkg::LP_SLEEP: sys_src = ism_pkg::SYS_NONE;
        endcase
      end
      ism_pkg::ST_SLEEP_WAKE: begin
        // Fast start runs the system on internal meanwhile
        cpu_clk_en = fast_start;
        periph_clk_en = fast_start;
        sys_src = fast_start ? ism_pkg::SYS_INTERNAL : ism_pkg::SYS_NONE;
      end
      ism_pkg::ST_SWITCH_BACK: begin
        sys_src = ism_pkg::SYS_NONE;
      end
    endcase
  end

  // Fast source follows the frequency field
  assign fast_internal_en = (freq != 3'h0);

  // Slow source for watchdog, monitor, zero-field internal use
  assign slow_internal_en = s_q.ctrl[ism_pkg::CTRL_WDT_EN] | s_q.ctrl[ism_pkg::CTRL_MON_EN] |
                            (fast_start && s_q.st == ism_pkg::ST_SLEEP_WAKE) |
                            (s_q.lp == ism_pkg::LP_INTERNAL && freq == 3'h0 && s_q.st != ism_pkg::ST_RUN);

endmodule

/* File: sim/ism_clock_manager_checker.sv */
// Port-level watch on the power-mode sequencer
module ism_clock_manager_checker #(
  parameter int SETTLE_CYCLES = 50,
  parameter int SWITCH_EDGES = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core and wake
  input wire logic sleep_instr,
  input wire logic forced_nop,
  input wire logic cpu_clk_en,
  input wire logic irq_wake,
  input wire logic wdt_timeout,
  input wire logic wdt_reset_req,
  // Oscillators and clock tree
  input wire logic primary_osc_clk,
  input wire logic secondary_osc_clk,
  input wire logic internal_mux_clk,
  input wire logic primary_ready,
  input wire logic secondary_running,
  input wire logic periph_clk_en,
  input wire logic [1:0] sys_src,
  input wire logic primary_osc_en,
  input wire logic fast_internal_en,
  input wire logic slow_internal_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Shadow of the control word, taken at the same write edge
  logic [11:0] ctrl_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q <= 12'h000;
    end else if (psel && penable && pwrite && paddr == ism_pkg::OFS_CTRL) begin
      ctrl_q <= pwdata[11:0];
    end
  end
  // Full power as seen at the ports
  logic run;
  assign run = cpu_clk_en && periph_clk_en && sys_src == ism_pkg::SYS_PRIMARY;
  // Halted cycles since a primary idle wake; saturates so a hang stays visible
  logic [10:0] wake_age;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || cpu_clk_en) begin
      wake_age <= 11'h000;
    end else if (wake_age != 11'h7FF && (wake_age != 11'h000 ||
                 (periph_clk_en && sys_src == ism_pkg::SYS_PRIMARY && $rose(irq_wake)))) begin
      wake_age <= wake_age + 11'h001;
    end
  end
  // Sleep request while running
  sequence sleep_req;
    run && sleep_instr;
  endsequence
  // Wake request in primary idle
  sequence pri_wake;
    !cpu_clk_en && periph_clk_en && sys_src == ism_pkg::SYS_PRIMARY && $rose(irq_wake);
  endsequence
  chk_sleep_stops: assert property (sleep_req ##0 (!ctrl_q[7] && ctrl_q[1:0] == 2'h0)
    |=> !primary_osc_en && !cpu_clk_en && !periph_clk_en) else $error("plain sleep left a clock on");
  chk_sleep_dark: assert property (!cpu_clk_en && sys_src == ism_pkg::SYS_NONE && ctrl_q[11:10] == 2'h0
    && !ctrl_q[7] && ctrl_q[1:0] == 2'h0 && !primary_ready |=> !periph_clk_en && !cpu_clk_en)
    else $error("clocks ran before primary ready");
  chk_idle_keeps: assert property (sleep_req ##0 (ctrl_q[7] && ctrl_q[1:0] == 2'h0)
    |=> !cpu_clk_en && periph_clk_en && primary_osc_en && sys_src == ism_pkg::SYS_PRIMARY)
    else $error("primary idle entry wrong");
  chk_sec_refused: assert property (sleep_req ##0 (ctrl_q[8:7] == 2'h1 && ctrl_q[1:0] == 2'h1)
    |=> forced_nop && cpu_clk_en ##1 !forced_nop) else $error("refused sleep not a single no-op");
  chk_switch_pause: assert property (sleep_req ##0 (ctrl_q[7] && (ctrl_q[1] || ctrl_q[8:0] == 9'h181))
    |=> (!periph_clk_en && !cpu_clk_en)[*8]) else $error("switch pause too short");
  chk_wdt_wakes: assert property (!cpu_clk_en |-> !wdt_reset_req)
    else $error("watchdog reset while halted");
  chk_wake_holdoff: assert property (pri_wake |-> (!cpu_clk_en)[*3])
    else $error("primary idle wake too soon");
  chk_wake_bound: assert property (wake_age != 11'h000 |-> wake_age <= 11'h44E
    && (!cpu_clk_en || sys_src == ism_pkg::SYS_PRIMARY)) else $error("primary idle wake wrong");
  chk_primary_src: assert property (sys_src == ism_pkg::SYS_PRIMARY |-> primary_osc_en)
    else $error("primary selected while stopped");
  chk_sec_waits: assert property ($rose(periph_clk_en) && sys_src == ism_pkg::SYS_SECONDARY
    |-> $past(secondary_running, 4)) else $error("peripherals clocked before secondary ran");
  chk_fast_off: assert property ((ctrl_q[6:4] == 3'h0)[*3] |-> !fast_internal_en)
    else $error("fast source on with zero field");
endmodule

bind ism_clock_manager ism_clock_manager_checker #(.SETTLE_CYCLES(SETTLE_CYCLES), .SWITCH_EDGES(SWITCH_EDGES)) u_chk (
  .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_instr,
  .forced_nop, .cpu_clk_en, .irq_wake, .wdt_timeout, .wdt_reset_req, .primary_osc_clk, .secondary_osc_clk,
  .internal_mux_clk, .primary_ready, .secondary_running, .periph_clk_en, .sys_src, .primary_osc_en,
  .fast_internal_en, .slow_internal_en);

/* File: sim/ism_clock_manager_test.sv */
// Self-checking bench for the power-mode sequencer
module ism_clock_manager_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench-driven inputs
  logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sleep_instr = 1'b0, irq_wake = 1'b0, wdt_timeout = 1'b0, primary_ready = 1'b1, secondary_running = 1'b1;
  logic primary_osc_clk = 1'b0, secondary_osc_clk = 1'b0, internal_mux_clk = 1'b0;
  // Design outputs
  logic [31:0] prdata;
  logic [1:0] sys_src;
  logic pready, pslverr, forced_nop, cpu_clk_en, wdt_reset_req, periph_clk_en;
  logic primary_osc_en, fast_internal_en, slow_internal_en;
  // Bookkeeping
  int err_total = 0;
  int n_checks = 0;
  int k;
  logic [31:0] rd;
  logic er;
  // 100 MHz clock; oscillators slower than half of it
  initial forever #5 ref_clk = ~ref_clk;
  // Primary and secondary stand still while stopped
  initial forever #30 primary_osc_clk = (primary_osc_en === 1'b1) ? ~primary_osc_clk : 1'b0;
  initial forever #45 secondary_osc_clk = secondary_running ? ~secondary_osc_clk : 1'b0;
  initial forever #25 internal_mux_clk = ~internal_mux_clk;
  // Short settle count keeps the run brief
  ism_clock_manager #(.SETTLE_CYCLES(50), .SWITCH_EDGES(8)) u_ism_clock_manager (
    .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_instr,
    .forced_nop, .cpu_clk_en, .irq_wake, .wdt_timeout, .wdt_reset_req, .primary_osc_clk, .secondary_osc_clk,
    .internal_mux_clk, .primary_ready, .secondary_running, .periph_clk_en, .sys_src, .primary_osc_en,
    .fast_internal_en, .slow_internal_en);
  // Compare and log
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  // Sleep pulse; returns where the new mode shows
  task automatic sleep_pulse;
    sleep_instr <= 1'b1;
    @(posedge ref_clk);
    sleep_instr <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Wake pulse, long enough for the synchroniser
  task automatic wake(input bit wdt);
    if (wdt) wdt_timeout <= 1'b1;
    else irq_wake <= 1'b1;
    repeat (3) @(posedge ref_clk);
    wdt_timeout <= 1'b0;
    irq_wake <= 1'b0;
  endtask
  // Bounded wait for the CPU, optionally on primary
  task automatic wait_on(input bit pri);
    for (k = 0; k < 3000 && !(cpu_clk_en === 1'b1 && (!pri || sys_src === ism_pkg::SYS_PRIMARY)); k++)
      @(posedge ref_clk);
    // A wait that runs out is a mismatch
    if (k == 3000) begin
      err_total++;
      $display("unexpected cpu wake: expected on, seen off");
    end
  endtask
  task automatic t_reset;
    rdchk("ctrl", ism_pkg::OFS_CTRL, 32'h0);
    rdchk("holdoff", ism_pkg::OFS_HOLDOFF, 32'h0000_03E8);
    rdchk("status", ism_pkg::OFS_STATUS, 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    chk("hole", 32'h2, {30'h0, er, |rd});
  endtask
  task automatic t_sleep;
    sleep_pulse();
    primary_ready <= 1'b0;
    chk("sleep clocks", 32'h0, {primary_osc_en, cpu_clk_en, periph_clk_en});
    rdchk("sleep status", ism_pkg::OFS_STATUS, 32'h30);
    wake(1'b0);
    repeat (10) @(posedge ref_clk);
    chk("dark wake", 32'h0, {cpu_clk_en, periph_clk_en});
    primary_ready <= 1'b1;
    wait_on(1'b1);
    rdchk("sleep back", ism_pkg::OFS_STATUS, 32'h1);
    rdchk("ctrl kept", ism_pkg::OFS_CTRL, 32'h0);
    // Fast start: internal source clocks the system while primary warms
    apb(1'b1, ism_pkg::OFS_CTRL, 32'h800);
    sleep_pulse();
    primary_ready <= 1'b0;
    wake(1'b0);
    repeat (10) @(posedge ref_clk);
    chk("fast wake", 32'hF, {cpu_clk_en, periph_clk_en, sys_src});
    primary_ready <= 1'b1;
    wait_on(1'b1);
  endtask
  // Two hold-off values; the wake spans must differ by exactly their gap
  task automatic t_primary_idle_mode;
    int n[2];
    apb(1'b1, ism_pkg::OFS_CTRL, 32'h80);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, ism_pkg::OFS_HOLDOFF, i ? 32'h14 : 32'h4);
      sleep_pulse();
      chk("primary_idle_mode", 32'hD, {cpu_clk_en, periph_clk_en, primary_osc_en, sys_src});
      rdchk("pri flag", ism_pkg::OFS_STATUS, 32'h31);
      wake(1'b0);
      wait_on(1'b1);
      n[i] = k;
      rdchk("pri back", ism_pkg::OFS_STATUS, 32'h1);
    end
    chk("holdoff span", 32'h10, 32'(n[1] - n[0]));
  endtask
  task automatic t_sec;
    apb(1'b1, ism_pkg::OFS_CTRL, 32'h81);
    sleep_pulse();
    chk("forced nop", 32'h3, {forced_nop, cpu_clk_en});
    secondary_running <= 1'b0;
    apb(1'b1, ism_pkg::OFS_CTRL, 32'h181);
    sleep_pulse();
    primary_ready <= 1'b0;
    repeat (40) @(posedge ref_clk);
    chk("sec waits", 32'h0, {31'h0, periph_clk_en});
    secondary_running <= 1'b1;
    for (k = 0; k < 500 && periph_clk_en !== 1'b1; k++) @(posedge ref_clk);
    chk("secondary_idle_mode", 32'h2, {cpu_clk_en, primary_osc_en, sys_src});
    rdchk("sec flag", ism_pkg::OFS_STATUS, 32'h34);
    wake(1'b1);
    chk("no reset", 32'h0, {31'h0, wdt_reset_req});
    wait_on(1'b0);
    chk("sec resume", 32'h2, {30'h0, sys_src});
    primary_ready <= 1'b1;
    wait_on(1'b1);
    rdchk("sec back", ism_pkg::OFS_STATUS, 32'h1);
    rdchk("ctrl kept", ism_pkg::OFS_CTRL, 32'h181);
    wake(1'b1);
    chk("run reset", 32'h1, {31'h0, wdt_reset_req});
  endtask
  // Internal idle, zero field then settled field with watchdog on
  task automatic t_int;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, ism_pkg::OFS_CTRL, i ? 32'h2B2 : 32'h83);
      sleep_pulse();
      primary_ready <= 1'b0;
      for (k = 0; k < 500 && periph_clk_en !== 1'b1; k++) @(posedge ref_clk);
      repeat (60) @(posedge ref_clk);
      chk("int idle", i ? 32'hB : 32'h3, {fast_internal_en, primary_osc_en, sys_src});
      rdchk("int flag", ism_pkg::OFS_STATUS, i ? 32'h32 : 32'h30);
      wake(1'b0);
      wait_on(1'b0);
      chk("int resume", 32'h3, {30'h0, sys_src});
      primary_ready <= 1'b1;
      wait_on(1'b1);
      rdchk("int back", ism_pkg::OFS_STATUS, 32'h1);
    end
    chk("slow kept", 32'h1, {31'h0, slow_internal_en});
  endtask
  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_sleep();
    t_primary_idle_mode();
    t_sec();
    t_int();
    final_report();
  end
  // Hang guard, well past the expected run
  initial begin
    #300us;
    err_total++;
    final_report();
  end
endmodule
